// >>> shared/tlic_regs.svh
// Operation
// - each source has its own priority bit choosing low or high level
// - high level preempts a low routine; nothing preempts a high routine
// - reset clears every priority bit, so all sources start at low level
// - simultaneous requests: high level first, then fixed source order
// - order runs from external 0 down to crystal-valid; vectors 0x0003 step 8
// - pending requests are sampled and decoded on every clock outside a vector call
// - best response is five clocks: one to detect, four for the call
// - a request pending at interrupt return waits one more instruction
// - worst unblocked response is eighteen clocks including return and divide
// - equal or higher level in service defers a request past its return
// - enable bit 7 gates all sources globally
// - enable bit 6 is a plain software flag
// - enable bits 5..0 mask timer2, uart, timer1, ext1, timer0, ext0
// - priority register holds bits 5..0 for those six sources, 1 is high
// - priority bits 7..6 read as ones and ignore writes
// - first extended enable masks comparators, counter array, window, smbus, spi
// - second extended enable masks crystal-valid, ext7..4, conversion, timer3
// - second extended enable bit 6 reads zero; software writes only zero
// - extended level registers mirror the extended enable bit positions
// - pending flags set regardless of masks; masks only block the request
// - flag still set after return raises a new request after next instruction
`ifndef TLIC_REGS_SVH
`define TLIC_REGS_SVH

`define TLIC_ADDR_ENABLE     8'ha8
`define TLIC_ADDR_PRIORITY   8'hb8
`define TLIC_ADDR_EXT_EN1    8'he6
`define TLIC_ADDR_EXT_EN2    8'he7
`define TLIC_ADDR_EXT_LVL1   8'hf6
`define TLIC_ADDR_EXT_LVL2   8'hf7

`define TLIC_RESET_BYTE      8'h00
`define TLIC_GATE_BIT        7
`define TLIC_PRIO_RD_ONES    8'hc0
`define TLIC_PRIO_WR_MASK    8'h3f
`define TLIC_EXT2_RSV_MASK   8'h40

`define TLIC_NUM_SRC         22
`define TLIC_VEC_BASE        16'h0003
`define TLIC_VEC_STEP        16'h0008
`define TLIC_CALL_CYCLES     3'h4

`endif

// >>> shared/tlic_pkg.sv
`default_nettype none
package tlic_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } tlic_sfr_req_type;

    typedef enum logic {
        SEQ_RUN,
        SEQ_CALL
    } tlic_seq_type;
endpackage
`default_nettype wire

// >>> hdl/tlic_top.sv
`include "tlic_regs.svh"
`default_nettype none
module tlic_top
    import tlic_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    input  wire logic                     ce,
    input  wire tlic_sfr_req_type         sfr_req,
    output var  logic [7:0]               sfr_rdata,
    input  wire logic [`TLIC_NUM_SRC-1:0] pend_flags,
    input  wire logic                     instr_end,
    input  wire logic                     interrupt_return_instr_end,
    output var  logic                     irq_req,
    output var  logic [15:0]              irq_vector,
    output var  logic                     call_active,
    output var  logic                     call_done,
    output var  logic                     in_service_high,
    output var  logic                     in_service_low
);

    logic                     rst_meta_n;
    logic                     rst_sync_n;
    logic [7:0]               basic_irq_enable;
    logic [7:0]               basic_irq_priority;
    logic [7:0]               extended_irq_enable_one;
    logic [7:0]               extended_irq_enable_two;
    logic [7:0]               extended_level_reg_one;
    logic [7:0]               extended_level_reg_two;
    logic                     global_irq_gate;
    logic [`TLIC_NUM_SRC-1:0] src_mask;
    logic [`TLIC_NUM_SRC-1:0] src_level;
    logic [`TLIC_NUM_SRC-1:0] elig_high;
    logic [`TLIC_NUM_SRC-1:0] elig_low;
    logic                     high_ok;
    logic                     low_ok;
    logic                     next_req;
    logic                     next_level;
    logic [4:0]               next_idx;
    logic                     req_level;
    logic                     call_start;
    logic                     interrupt_return_instr_seen;
    tlic_seq_type             seq_state;
    logic [2:0]               call_cnt;

    // lowest index wins inside a level
    function automatic logic [4:0] first_set(input logic [`TLIC_NUM_SRC-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = `TLIC_NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] vec_of(input logic [4:0] idx);
        return 16'(`TLIC_VEC_BASE + `TLIC_VEC_STEP * {11'h000, idx});
    endfunction

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // special function register writes
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            basic_irq_enable        <= `TLIC_RESET_BYTE;
            basic_irq_priority      <= `TLIC_RESET_BYTE;
            extended_irq_enable_one <= `TLIC_RESET_BYTE;
            extended_irq_enable_two <= `TLIC_RESET_BYTE;
            extended_level_reg_one  <= `TLIC_RESET_BYTE;
            extended_level_reg_two  <= `TLIC_RESET_BYTE;
        end
        else if (ce && sfr_req.wr)
        begin
            case (sfr_req.addr)
                `TLIC_ADDR_ENABLE:
                begin
                    basic_irq_enable <= sfr_req.wdata;
                end
                `TLIC_ADDR_PRIORITY:
                begin
                    basic_irq_priority <= sfr_req.wdata & `TLIC_PRIO_WR_MASK;
                end
                `TLIC_ADDR_EXT_EN1:
                begin
                    extended_irq_enable_one <= sfr_req.wdata;
                end
                `TLIC_ADDR_EXT_EN2:
                begin
                    extended_irq_enable_two <= sfr_req.wdata & ~`TLIC_EXT2_RSV_MASK;
                end
                `TLIC_ADDR_EXT_LVL1:
                begin
                    extended_level_reg_one <= sfr_req.wdata;
                end
                `TLIC_ADDR_EXT_LVL2:
                begin
                    extended_level_reg_two <= sfr_req.wdata & ~`TLIC_EXT2_RSV_MASK;
                end
                default:
                begin
                end
            endcase
        end
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sfr_rdata <= 8'h00;
        end
        else if (ce && sfr_req.rd)
        begin
            case (sfr_req.addr)
                `TLIC_ADDR_ENABLE:   sfr_rdata <= basic_irq_enable;
                `TLIC_ADDR_PRIORITY: sfr_rdata <= basic_irq_priority | `TLIC_PRIO_RD_ONES;
                `TLIC_ADDR_EXT_EN1:  sfr_rdata <= extended_irq_enable_one;
                `TLIC_ADDR_EXT_EN2:  sfr_rdata <= extended_irq_enable_two;
                `TLIC_ADDR_EXT_LVL1: sfr_rdata <= extended_level_reg_one;
                `TLIC_ADDR_EXT_LVL2: sfr_rdata <= extended_level_reg_two;
                default:             sfr_rdata <= 8'h00;
            endcase
        end
    end

    assign global_irq_gate = basic_irq_enable[`TLIC_GATE_BIT];
    // source rank equals bit index of these vectors
    assign src_mask  = {extended_irq_enable_two & ~`TLIC_EXT2_RSV_MASK,
                        extended_irq_enable_one,
                        basic_irq_enable[5:0]};
    assign src_level = {extended_level_reg_two & ~`TLIC_EXT2_RSV_MASK,
                        extended_level_reg_one,
                        basic_irq_priority[5:0]};

    genvar g;
    generate
        for (g = 0; g < `TLIC_NUM_SRC; g++)
        begin : g_src
            // flags arrive unmasked; masking only blocks the request
            assign elig_high[g] = pend_flags[g] & src_mask[g] & global_irq_gate
                                  & src_level[g];
            assign elig_low[g]  = pend_flags[g] & src_mask[g] & global_irq_gate
                                  & ~src_level[g];
        end
    endgenerate

    assign high_ok    = (|elig_high) && !in_service_high;
    assign low_ok     = (|elig_low) && !in_service_high && !in_service_low;
    assign next_req   = high_ok || low_ok;
    assign next_level = high_ok;
    assign next_idx   = high_ok ? first_set(elig_high) : first_set(elig_low);

    // a return's own end never starts a call, so one instruction follows
    assign interrupt_return_instr_seen  = instr_end && interrupt_return_instr_end;
    assign call_start = ce && instr_end && irq_req && !interrupt_return_instr_end
                        && (seq_state == SEQ_RUN);

    // request sampled and decoded every clock outside a vector call
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            irq_req    <= 1'b0;
            irq_vector <= `TLIC_VEC_BASE;
            req_level  <= 1'b0;
        end
        else if (ce)
        begin
            if (seq_state == SEQ_RUN && !call_start)
            begin
                irq_req    <= next_req;
                irq_vector <= vec_of(next_idx);
                req_level  <= next_level;
            end
            else
            begin
                irq_req <= 1'b0;
            end
        end
    end

    // vector call sequencer
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            seq_state   <= SEQ_RUN;
            call_cnt    <= 3'h0;
            call_active <= 1'b0;
            call_done   <= 1'b0;
        end
        else if (ce)
        begin
            call_done <= 1'b0;
            case (seq_state)
                SEQ_RUN:
                begin
                    if (call_start)
                    begin
                        seq_state   <= SEQ_CALL;
                        call_cnt    <= `TLIC_CALL_CYCLES - 3'h1;
                        call_active <= 1'b1;
                    end
                end
                SEQ_CALL:
                begin
                    if (call_cnt == 3'h0)
                    begin
                        seq_state   <= SEQ_RUN;
                        call_active <= 1'b0;
                    end
                    else
                    begin
                        call_cnt  <= call_cnt - 3'h1;
                        call_done <= (call_cnt == 3'h1);
                    end
                end
                default:
                begin
                    seq_state   <= SEQ_RUN;
                    call_active <= 1'b0;
                end
            endcase
        end
    end

    // in-service markers per level
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            in_service_high <= 1'b0;
            in_service_low  <= 1'b0;
        end
        else if (ce)
        begin
            if (call_start)
            begin
                if (req_level)
                begin
                    in_service_high <= 1'b1;
                end
                else
                begin
                    in_service_low <= 1'b1;
                end
            end
            else if (interrupt_return_instr_seen)
            begin
                if (in_service_high)
                begin
                    in_service_high <= 1'b0;
                end
                else
                begin
                    in_service_low <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_sync_n || !ce);

    sequence call_run_s;
        call_active [*4] ##1 !call_active;
    endsequence

    sequence done_at_end_s;
        !call_done [*3] ##1 call_done;
    endsequence

    call_length_a: assert property (
        call_start |=> call_run_s)
        else $error("vector call did not last four cycles");

    call_done_a: assert property (
        call_start |=> done_at_end_s)
        else $error("call done not in fourth call cycle");

    gate_block_a: assert property (
        !global_irq_gate |=> !irq_req)
        else $error("request raised with global gate off");

    high_nopreempt_a: assert property (
        in_service_high |=> !irq_req)
        else $error("request raised during high routine");

    low_defer_a: assert property (
        in_service_low && !(|elig_high) |=> !irq_req)
        else $error("low request during low routine");

    interrupt_return_instr_wait_a: assert property (
        interrupt_return_instr_seen |=> !call_active)
        else $error("call made at end of return");

    prio_ones_a: assert property (
        sfr_req.rd && sfr_req.addr == `TLIC_ADDR_PRIORITY
        |=> sfr_rdata[7:6] == 2'b11)
        else $error("priority top bits not read as ones");

    resv_zero_a: assert property (
        sfr_req.rd && sfr_req.addr == `TLIC_ADDR_EXT_EN2
        |=> sfr_rdata[6] == 1'b0)
        else $error("reserved enable bit not read as zero");

    vec_shape_a: assert property (
        irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h00ab
                    && irq_vector != 16'h00a3)
        else $error("vector outside table");

    level_pick_a: assert property (
        seq_state == SEQ_RUN && !call_start && |elig_high && !in_service_high
        |=> irq_req && req_level)
        else $error("high request not chosen first");

    mark_set_a: assert property (
        call_start && req_level |=> in_service_high)
        else $error("high marker not set on call");

    mask_gate_a: assert property (
        seq_state == SEQ_RUN && !call_start && !(|(pend_flags & src_mask))
        |=> !irq_req)
        else $error("request without pending masked source");

endmodule // tlic_top
`default_nettype wire

// >>> bench/tlic_core_model.sv
`default_nettype none
module tlic_core_model (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic run,
    input  wire logic slow,
    input  wire logic interrupt_return_instr_req,
    input  wire logic call_active,
    output var  logic instr_end,
    output var  logic interrupt_return_instr_end
);
    timeunit 1ns;
    timeprecision 100ps;
    logic phase;
    initial
    begin
        instr_end = 1'b0;
        interrupt_return_instr_end = 1'b0;
        phase = 1'b0;
    end
    // acts after the bench stimulus and the block's own updates have settled
    always @(posedge clk_sys)
    begin
        #2;
        phase = ~phase;
        // slow mode ends an instruction every other cycle; none during a call
        instr_end = reset_n && run && !call_active && (!slow || phase);
        interrupt_return_instr_end = instr_end && interrupt_return_instr_req;
    end
endmodule // tlic_core_model
`default_nettype wire

// >>> bench/test_two_level_interrupt_controller.sv
`include "tlic_regs.svh"
`default_nettype none
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module test_two_level_interrupt_controller
    import tlic_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                     clk_sys = 1'b0;
    logic                     reset_n = 1'b0;
    logic                     ce = 1'b1;
    tlic_sfr_req_type         sfr_req = '0;
    logic [`TLIC_NUM_SRC-1:0] pend_flags = '0;
    logic                     run = 1'b0;
    logic                     slow = 1'b0;
    logic                     interrupt_return_instr_req = 1'b0;
    logic [7:0]               sfr_rdata;
    logic                     instr_end;
    logic                     interrupt_return_instr_end;
    logic                     irq_req;
    logic [15:0]              irq_vector;
    logic                     call_active;
    logic                     call_done;
    logic                     in_service_high;
    logic                     in_service_low;
    int                       err_count = 0;
    int                       samples_checked = 0;
    int                       n;

    always #4 clk_sys = ~clk_sys;

    tlic_top DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .pend_flags(pend_flags), .instr_end(instr_end),
        .interrupt_return_instr_end(interrupt_return_instr_end), .irq_req(irq_req), .irq_vector(irq_vector),
        .call_active(call_active), .call_done(call_done),
        .in_service_high(in_service_high), .in_service_low(in_service_low)
    );
    tlic_core_model core (
        .clk_sys(clk_sys), .reset_n(reset_n), .run(run), .slow(slow),
        .interrupt_return_instr_req(interrupt_return_instr_req), .call_active(call_active), .instr_end(instr_end),
        .interrupt_return_instr_end(interrupt_return_instr_end)
    );

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // one idle cycle after each access keeps the strobes single pulses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{a, 1'b1, 1'b0, d};
        tick(1);
        sfr_req = '0;
        tick(1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        sfr_req = '{a, 1'b0, 1'b1, 8'h00};
        tick(1);
        sfr_req = '0;
        `CHK(sfr_rdata, e)
        tick(1);
    endtask

    task automatic wait_done(output int k);
        for (k = 0; k == 0 || (call_done !== 1'b1 && k < 20); k++)
            tick(1);
        `CHK(call_done, 1'b1)
    endtask

    task automatic t_regs();
        logic [7:0] adr [6];
        logic [7:0] wv [6];
        adr = '{8'ha8, 8'hb8, 8'he6, 8'he7, 8'hf6, 8'hf7};
        wv = '{8'hbf, 8'hff, 8'hff, 8'hbf, 8'hff, 8'hbf};
        for (int i = 0; i < 6; i++)
            rd_chk(adr[i], (i == 1) ? 8'hc0 : 8'h00);
        for (int i = 0; i < 6; i++)
            wr(adr[i], wv[i]);
        for (int i = 0; i < 6; i++)
            rd_chk(adr[i], wv[i]);
        wr(8'hb8, 8'h00);
        rd_chk(8'hb8, 8'hc0);
        wr(8'ha8, 8'h40);
        pend_flags = '1;
        tick(2);
        `CHK(irq_req, 1'b0)
        rd_chk(8'ha8, 8'h40);
        ce = 1'b0;
        wr(8'ha8, 8'h81);
        ce = 1'b1;
        rd_chk(8'ha8, 8'h40);
        wr(8'h55, 8'hff);
        rd_chk(8'h55, 8'h00);
        pend_flags = '0;
        wr(8'hf6, 8'h00);
        wr(8'hf7, 8'h00);
    endtask

    task automatic t_order();
        wr(8'ha8, 8'hbf);
        for (int r = 0; r < `TLIC_NUM_SRC; r++)
        begin
            pend_flags = '0;
            pend_flags[r] = 1'b1;
            tick(2);
            `CHK(irq_req, (r != 20))
            if (r != 20)
                `CHK(irq_vector, 16'h0003 + 16'(8 * r))
        end
        pend_flags = '1;
        tick(2);
        `CHK(irq_vector, 16'h0003)
        wr(8'hf7, 8'h80);
        `CHK(irq_vector, 16'h00ab)
        wr(8'hb8, 8'h20);
        `CHK(irq_vector, 16'h002b)
        wr(8'ha8, 8'h9f);
        `CHK(irq_vector, 16'h00ab)
        wr(8'ha8, 8'h3f);
        `CHK(irq_req, 1'b0)
        pend_flags = '0;
        wr(8'hb8, 8'h00);
        wr(8'hf7, 8'h00);
    endtask

    task automatic t_best();
        wr(8'ha8, 8'h81);
        run = 1'b1;
        tick(1);
        pend_flags[0] = 1'b1;
        wait_done(n);
        `CHK(n, 5)
        `CHK(irq_vector, 16'h0003)
        `CHK(in_service_low, 1'b1)
        tick(1);
        `CHK(call_active, 1'b0)
        tick(3);
        `CHK(irq_req, 1'b0)
    endtask

    task automatic t_preempt();
        slow = 1'b1;
        wr(8'hb8, 8'h02);
        wr(8'ha8, 8'h87);
        pend_flags[1] = 1'b1;
        wait_done(n);
        `CHK(irq_vector, 16'h000b)
        `CHK(in_service_high, 1'b1)
        wr(8'hb8, 8'h06);
        pend_flags[2] = 1'b1;
        tick(6);
        `CHK(irq_req, 1'b0)
        // the high routine clears its own flag before returning
        pend_flags[1] = 1'b0;
        interrupt_return_instr_req = 1'b1;
        for (n = 0; n < 8 && interrupt_return_instr_end !== 1'b1; n++)
            tick(1);
        interrupt_return_instr_req = 1'b0;
        tick(1);
        `CHK(in_service_high, 1'b0)
        `CHK(in_service_low, 1'b1)
        `CHK(call_active, 1'b0)
        wait_done(n);
        `CHK(irq_vector, 16'h0013)
        `CHK(in_service_high, 1'b1)
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        tick(6);
        t_regs();
        t_order();
        t_best();
        t_preempt();
        report_and_stop();
    end

    initial
    begin
        #50us;
        err_count++;
        report_and_stop();
    end
endmodule // test_two_level_interrupt_controller
`default_nettype wire
